// *** include/asm_pkg.sv ***
/*
 * Shared constants for the two-channel asynchronous serial block:
 * internal I/O offsets, register field positions, reset values and
 * the state encodings of the transmit and receive sequencers.
 * Assumes an 8-bit internal I/O space decoded by the block itself.
 */
`default_nettype none

package asm_pkg;

    // internal I/O offsets
    localparam logic [7:0] ASM_OFS_CTL_A0  = 8'h00;
    localparam logic [7:0] ASM_OFS_CTL_A1  = 8'h01;
    localparam logic [7:0] ASM_OFS_CTL_B0  = 8'h02;
    localparam logic [7:0] ASM_OFS_CTL_B1  = 8'h03;
    localparam logic [7:0] ASM_OFS_SERIAL_STATUS_CH0   = 8'h04;
    localparam logic [7:0] ASM_OFS_SERIAL_STATUS_CH1   = 8'h05;
    localparam logic [7:0] ASM_OFS_TXD0    = 8'h06;
    localparam logic [7:0] ASM_OFS_TXD1    = 8'h07;
    localparam logic [7:0] ASM_OFS_RXD0    = 8'h08;
    localparam logic [7:0] ASM_OFS_RXD1    = 8'h09;

    // serial control register A fields
    localparam int ASM_A_STOP_COUNT  = 0;
    localparam int ASM_A_FMT_MIDDLE  = 1;
    localparam int ASM_A_DATA_LENGTH = 2;
    localparam int ASM_A_ERR_KEEP    = 3;
    localparam int ASM_A_RX_ADDR     = 7;

    // serial control register B fields
    localparam int ASM_B_PAR_ODD     = 4;
    localparam int ASM_B_MP_ENABLE   = 6;
    localparam int ASM_B_ADDR_TX     = 7;

    // status register fields
    localparam int ASM_S_TX_IE       = 0;
    localparam int ASM_S_TX_EMPTY    = 1;
    localparam int ASM_S_CARRIER     = 2;
    localparam int ASM_S_RX_IE       = 3;
    localparam int ASM_S_FRAME_ERR   = 4;
    localparam int ASM_S_PARITY_ERR  = 5;
    localparam int ASM_S_OVERRUN     = 6;
    localparam int ASM_S_RX_FULL     = 7;

    // values after reset
    localparam logic [7:0] ASM_CTL_A_RST = 8'h00;
    localparam logic [7:0] ASM_CTL_B_RST = 8'h07;

    // default bit time in system clocks
    localparam int ASM_BIT_CYCLES_DEF = 16;

    typedef enum logic [0:0] {
        ASM_TX_IDLE = 1'b0,
        ASM_TX_SEND = 1'b1
    } asm_tx_e;

    typedef enum logic [1:0] {
        ASM_RX_IDLE  = 2'b00,
        ASM_RX_START = 2'b01,
        ASM_RX_DATA  = 2'b11
    } asm_rx_e;

endpackage

`default_nettype wire

// *** rtl/asm_serial.sv ***
/*
 * Two-channel asynchronous serial channel with multiprocessor framing,
 * status registers and control registers on the internal I/O port.
 * Assumes single-cycle read and write strobes synchronous to clk_sys_in
 * and serial inputs already synchronous to the same clock.
 */
//
// Contract
// - with multiprocessor framing on, the sent address flag equals bit 7 of control B.
// - the address-flag transmit bit lives at control B bit 7 and has no defined reset value.
// - control B bit 6 set to 1 selects multiprocessor framing; length and stops still come from control A.
// - a multiprocessor frame is start, 7 or 8 data, address flag, 1 or 2 stops, both directions.
// - multiprocessor framing neither generates nor checks parity.
// - with bit 6 at 0 the frame follows the three format bits of control A, parity included.
// - reset clears the multiprocessor-format bit to 0.
// - channel 0 status bits 7..0 are rx full, overrun, parity, framing, rx ie, carrier, tx empty, tx ie.
// - reset clears rx full, overrun, parity, framing and tx ie of channel 0.
// - channel 1 status matches channel 0 except bit 2 holds the clear-to-send interrupt enable; here that bit always reads 0.
// - after reset channel 1 status reads with only tx empty set.
// - control B of channel 0 is at offset 02H and of channel 1 at 03H.
`default_nettype none

module asm_serial
    import asm_pkg::*;
#(
    parameter int BIT_CYCLES = ASM_BIT_CYCLES_DEF
) (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       nrst_in,
    // internal I/O port
    input  wire logic [7:0] io_addr_in,
    input  wire logic       io_wr_in,
    input  wire logic       io_rd_in,
    input  wire logic [7:0] io_wdata_in,
    output logic      [7:0] io_rdata_out,
    // serial lines
    input  wire logic [1:0] rxd_in,
    output logic      [1:0] txd_out,
    input  wire logic       carrier_detect_in,
    // interrupt requests
    output logic      [1:0] rx_irq_out,
    output logic      [1:0] tx_irq_out
);

    // elaboration check: the bit time needs at least 4 clocks, a half bit at least 2
    if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bad_bit_cycles
        $error("BIT_CYCLES out of range");
    end

    localparam logic [15:0] BIT_LAST  = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);

    typedef struct packed {
        logic    [1:0][7:0]  ctl_a;
        logic    [1:0][7:0]  ctl_b;
        logic    [1:0][7:0]  tx_data;
        logic    [1:0][7:0]  rx_data;
        logic    [1:0]       rx_full;
        logic    [1:0]       overrun;
        logic    [1:0]       par_err;
        logic    [1:0]       frm_err;
        logic    [1:0]       rx_ie;
        logic    [1:0]       tx_ie;
        logic    [1:0]       tx_empty;
        logic                carrier;
        asm_tx_e [1:0]       tx_st;
        logic    [1:0][11:0] tx_sh;
        logic    [1:0][3:0]  tx_cnt;
        logic    [1:0][15:0] tx_div;
        asm_rx_e [1:0]       rx_st;
        logic    [1:0][11:0] rx_bits;
        logic    [1:0][3:0]  rx_cnt;
        logic    [1:0][15:0] rx_div;
        logic    [1:0]       txd;
        logic    [7:0]       rdata;
        logic    [1:0]       rx_irq;
        logic    [1:0]       tx_irq;
    } asm_state_s;

    asm_state_s s_q;
    asm_state_s s_d;

    // true when the frame carries a bit between data and stop
    function automatic logic has_extra(input logic [7:0] a, input logic [7:0] b);
        return b[ASM_B_MP_ENABLE] | a[ASM_A_FMT_MIDDLE];
    endfunction

    // index of the first stop bit; start sits at 0
    function automatic logic [3:0] stop_pos(input logic [7:0] a,
                                            input logic [7:0] b);
        return 4'd8 + {3'd0, a[ASM_A_DATA_LENGTH]}
             + {3'd0, has_extra(a, b)};
    endfunction

    // parity over the active data bits, odd when control B asks
    function automatic logic parity(input logic [7:0] d, input logic [7:0] a,
                                    input logic [7:0] b);
        logic p;
        p = ^d[6:0] ^ b[ASM_B_PAR_ODD];
        if (a[ASM_A_DATA_LENGTH]) begin
            p = p ^ d[7];
        end
        return p;
    endfunction

    // whole frame, least significant bit first, idle ones beyond it
    function automatic logic [11:0] tx_frame(input logic [7:0] d,
                                             input logic [7:0] a,
                                             input logic [7:0] b);
        logic [11:0] f;
        logic [3:0]  p;
        f = 12'hFFF;
        f[0] = 1'b0;
        f[7:1] = d[6:0];
        if (a[ASM_A_DATA_LENGTH]) begin
            f[8] = d[7];
        end
        p = 4'd8 + {3'd0, a[ASM_A_DATA_LENGTH]};
        if (b[ASM_B_MP_ENABLE]) begin
            f[p] = b[ASM_B_ADDR_TX];
        end else if (a[ASM_A_FMT_MIDDLE]) begin
            f[p] = parity(d, a, b);
        end
        return f;
    endfunction

    // status byte; channel 1 shows its clear-to-send enable, held at 0
    function automatic logic [7:0] status(input asm_state_s s, input int c);
        logic [7:0] v;
        v = 8'h00;
        v[ASM_S_RX_FULL]    = s.rx_full[c];
        v[ASM_S_OVERRUN]    = s.overrun[c];
        v[ASM_S_PARITY_ERR] = s.par_err[c];
        v[ASM_S_FRAME_ERR]  = s.frm_err[c];
        v[ASM_S_RX_IE]      = s.rx_ie[c];
        v[ASM_S_CARRIER]    = (c == 0) ? s.carrier : 1'b0;
        v[ASM_S_TX_EMPTY]   = s.tx_empty[c];
        v[ASM_S_TX_IE]      = s.tx_ie[c];
        return v;
    endfunction

    // next state: bus accesses first, except transmit data writes, so that line events win over clears
    always_comb begin
        logic [7:0]  a;
        logic [7:0]  b;
        logic [11:0] rb;
        logic [3:0]  sp;
        logic        bad_par;
        s_d = s_q;
        a = 8'h00;
        b = 8'h00;
        rb = 12'h000;
        sp = 4'd0;
        bad_par = 1'b0;
        s_d.carrier = carrier_detect_in;
        if (io_rd_in) begin
            unique case (io_addr_in)
                ASM_OFS_CTL_A0: s_d.rdata = s_q.ctl_a[0];
                ASM_OFS_CTL_A1: s_d.rdata = s_q.ctl_a[1];
                ASM_OFS_CTL_B0: s_d.rdata = s_q.ctl_b[0];
                ASM_OFS_CTL_B1: s_d.rdata = s_q.ctl_b[1];
                ASM_OFS_SERIAL_STATUS_CH0:  s_d.rdata = status(s_q, 0);
                ASM_OFS_SERIAL_STATUS_CH1:  s_d.rdata = status(s_q, 1);
                ASM_OFS_TXD0:   s_d.rdata = s_q.tx_data[0];
                ASM_OFS_TXD1:   s_d.rdata = s_q.tx_data[1];
                ASM_OFS_RXD0: begin
                    s_d.rdata = s_q.rx_data[0];
                    s_d.rx_full[0] = 1'b0;
                end
                ASM_OFS_RXD1: begin
                    s_d.rdata = s_q.rx_data[1];
                    s_d.rx_full[1] = 1'b0;
                end
                default:        s_d.rdata = 8'h00;
            endcase
        end
        // register writes; status takes only the two enables
        if (io_wr_in) begin
            for (int c = 0; c < 2; c++) begin
                if (io_addr_in == ASM_OFS_CTL_A0 + 8'(c)) begin
                    s_d.ctl_a[c] = {1'b0, io_wdata_in[6:0]};
                    if (!io_wdata_in[ASM_A_ERR_KEEP]) begin
                        s_d.overrun[c] = 1'b0;
                        s_d.par_err[c] = 1'b0;
                        s_d.frm_err[c] = 1'b0;
                    end
                end
                if (io_addr_in == ASM_OFS_CTL_B0 + 8'(c)) begin
                    s_d.ctl_b[c] = io_wdata_in;
                end
                if (io_addr_in == ASM_OFS_SERIAL_STATUS_CH0 + 8'(c)) begin
                    s_d.rx_ie[c] = io_wdata_in[ASM_S_RX_IE];
                    s_d.tx_ie[c] = io_wdata_in[ASM_S_TX_IE];
                end
            end
        end
        for (int c = 0; c < 2; c++) begin
            a = s_q.ctl_a[c];
            b = s_q.ctl_b[c];
            sp = stop_pos(a, b);
            // transmitter: take a byte, then shift one bit per bit time
            unique case (s_q.tx_st[c])
                ASM_TX_IDLE: begin
                    s_d.txd[c] = 1'b1;
                    if (!s_q.tx_empty[c]) begin
                        s_d.tx_sh[c] = tx_frame(s_q.tx_data[c], a, b);
                        s_d.tx_cnt[c] = sp + {3'd0, a[ASM_A_STOP_COUNT]};
                        s_d.tx_div[c] = 16'h0000;
                        s_d.tx_empty[c] = 1'b1;
                        s_d.tx_st[c] = ASM_TX_SEND;
                    end
                end
                ASM_TX_SEND: begin
                    s_d.txd[c] = s_q.tx_sh[c][0];
                    s_d.tx_div[c] = s_q.tx_div[c] + 16'h0001;
                    if (s_q.tx_div[c] == BIT_LAST) begin
                        s_d.tx_div[c] = 16'h0000;
                        s_d.tx_sh[c] = {1'b1, s_q.tx_sh[c][11:1]};
                        s_d.tx_cnt[c] = s_q.tx_cnt[c] - 4'd1;
                        if (s_q.tx_cnt[c] == 4'd0) begin
                            s_d.txd[c] = 1'b1;
                            s_d.tx_st[c] = ASM_TX_IDLE;
                        end
                    end
                end
            endcase
            // a write to transmit data refills the holding register
            if (io_wr_in && io_addr_in == ASM_OFS_TXD0 + 8'(c)) begin
                s_d.tx_data[c] = io_wdata_in;
                s_d.tx_empty[c] = 1'b0;
            end
            // receiver: verify start at mid bit, then sample each bit
            unique case (s_q.rx_st[c])
                ASM_RX_IDLE: begin
                    s_d.rx_div[c] = 16'h0000;
                    if (!rxd_in[c]) begin
                        s_d.rx_st[c] = ASM_RX_START;
                    end
                end
                ASM_RX_START: begin
                    s_d.rx_div[c] = s_q.rx_div[c] + 16'h0001;
                    if (s_q.rx_div[c] == HALF_LAST) begin
                        s_d.rx_div[c] = 16'h0000;
                        s_d.rx_cnt[c] = 4'd1;
                        s_d.rx_st[c] = rxd_in[c] ? ASM_RX_IDLE : ASM_RX_DATA;
                    end
                end
                ASM_RX_DATA: begin
                    s_d.rx_div[c] = s_q.rx_div[c] + 16'h0001;
                    if (s_q.rx_div[c] == BIT_LAST) begin
                        s_d.rx_div[c] = 16'h0000;
                        rb = s_q.rx_bits[c];
                        rb[s_q.rx_cnt[c]] = rxd_in[c];
                        s_d.rx_bits[c] = rb;
                        s_d.rx_cnt[c] = s_q.rx_cnt[c] + 4'd1;
                        // only the first stop is checked, so a second
                        // stop overlaps the search for the next start
                        if (s_q.rx_cnt[c] == sp) begin
                            s_d.rx_st[c] = ASM_RX_IDLE;
                            bad_par = a[ASM_A_FMT_MIDDLE]
                                & !b[ASM_B_MP_ENABLE]
                                & (parity(rb[8:1], a, b) != rb[sp - 4'd1]);
                            // built on s_d so a same-cycle clear is kept
                            s_d.par_err[c] = s_d.par_err[c] | bad_par;
                            s_d.frm_err[c] = s_d.frm_err[c] | !rb[sp];
                            if (s_d.rx_full[c]) begin
                                s_d.overrun[c] = 1'b1;
                            end else begin
                                s_d.rx_data[c] = a[ASM_A_DATA_LENGTH]
                                    ? rb[8:1] : {1'b0, rb[7:1]};
                                s_d.ctl_a[c][ASM_A_RX_ADDR] =
                                    b[ASM_B_MP_ENABLE] & rb[sp - 4'd1];
                                s_d.rx_full[c] = 1'b1;
                            end
                        end
                    end
                end
                default: s_d.rx_st[c] = ASM_RX_IDLE;
            endcase
            // requests registered so the outputs leave flip-flops
            s_d.rx_irq[c] = s_d.rx_ie[c] & (s_d.rx_full[c] | s_d.overrun[c]
                | s_d.par_err[c] | s_d.frm_err[c]);
            s_d.tx_irq[c] = s_d.tx_ie[c] & s_d.tx_empty[c];
        end
    end

    // state register; every field takes a constant under reset
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q <= '0;
            s_q.ctl_a <= {ASM_CTL_A_RST, ASM_CTL_A_RST};
            s_q.ctl_b <= {ASM_CTL_B_RST, ASM_CTL_B_RST};
            s_q.tx_empty <= 2'b11;
            s_q.txd <= 2'b11;
        end else begin
            s_q <= s_d;
        end
    end

    assign io_rdata_out = s_q.rdata;
    assign txd_out      = s_q.txd;
    assign rx_irq_out   = s_q.rx_irq;
    assign tx_irq_out   = s_q.tx_irq;

endmodule

`default_nettype wire

// *** verification/asm_serial_props.sv ***
/*
 * Port-level assertions for the two-channel serial block.
 * Assumes the bind hands on the same bit time as the bound instance.
 */
`default_nettype none

module asm_serial_props
    import asm_pkg::*;
#(
    parameter int BIT_CYCLES = ASM_BIT_CYCLES_DEF
) (
    // clock and reset
    input wire logic       clk_sys_in,
    input wire logic       nrst_in,
    // internal I/O port
    input wire logic [7:0] io_addr_in,
    input wire logic       io_wr_in,
    input wire logic       io_rd_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic [7:0] io_rdata_out,
    // serial lines and requests
    input wire logic [1:0] rxd_in,
    input wire logic [1:0] txd_out,
    input wire logic       carrier_detect_in,
    input wire logic [1:0] rx_irq_out,
    input wire logic [1:0] tx_irq_out
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    // low run length on channel 0, so whole bit times can be checked
    logic [15:0] low_run_q;
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            low_run_q <= 16'h0000;
        end else begin
            low_run_q <= txd_out[0] ? 16'h0000 : low_run_q + 16'h0001;
        end
    end

    a_reset_lines_idle: assert property (
        $rose(nrst_in) |-> txd_out == 2'b11 && tx_irq_out == 2'b00
            && rx_irq_out == 2'b00) else $error("lines busy after reset");
    a_unmapped_reads_zero: assert property (
        io_rd_in && io_addr_in > ASM_OFS_RXD1 |=> io_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !io_rd_in |=> $stable(io_rdata_out)) else $error("read data moved");
    a_ctlb_readback: assert property (
        io_wr_in && io_addr_in == ASM_OFS_CTL_B0 ##1
        io_rd_in && io_addr_in == ASM_OFS_CTL_B0
        |=> io_rdata_out == $past(io_wdata_in, 2))
        else $error("control B readback wrong");
    a_serial_status_ch1_write_mask: assert property (
        io_wr_in && io_addr_in == ASM_OFS_SERIAL_STATUS_CH1 ##1
        io_rd_in && io_addr_in == ASM_OFS_SERIAL_STATUS_CH1
        |=> io_rdata_out[3] == $past(io_wdata_in[3], 2)
            && io_rdata_out[0] == $past(io_wdata_in[0], 2)
            && !io_rdata_out[2]) else $error("status write mask wrong");
    a_tx_req_off: assert property (
        io_wr_in && io_addr_in == ASM_OFS_SERIAL_STATUS_CH0 && !io_wdata_in[0]
        |-> ##2 !tx_irq_out[0]) else $error("tx request without enable");
    a_rx_req_off: assert property (
        io_wr_in && io_addr_in == ASM_OFS_SERIAL_STATUS_CH0 && !io_wdata_in[3]
        |-> ##2 !rx_irq_out[0]) else $error("rx request without enable");
    a_whole_bit_times: assert property (
        $rose(txd_out[0]) |-> low_run_q != 16'h0000
            && (low_run_q % BIT_CYCLES) == 0)
        else $error("low run not whole bits");

    // main scenarios
    c_tx_write: cover property (io_wr_in && io_addr_in == ASM_OFS_TXD0);
    c_rx_req: cover property ($rose(rx_irq_out[1]));
    c_tx_req: cover property ($rose(tx_irq_out[0]));
endmodule

bind asm_serial asm_serial_props #(.BIT_CYCLES(BIT_CYCLES)) u_props (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .io_addr_in(io_addr_in),
    .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
    .io_rdata_out(io_rdata_out), .rxd_in(rxd_in), .txd_out(txd_out),
    .carrier_detect_in(carrier_detect_in), .rx_irq_out(rx_irq_out),
    .tx_irq_out(tx_irq_out)
);

`default_nettype wire

// *** verification/asm_remote.sv ***
/*
 * Remote station on one serial line: sends frames, samples frames.
 * Assumes the same bit time in system clocks as the serial block.
 */
`default_nettype none

module asm_remote #(
    parameter int BIT_CYCLES = 4
) (
    // clock and line
    input  wire logic clk_sys_in,
    input  wire logic line_in,
    output var  logic line_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle line rests at mark
    initial line_out = 1'b1;

    // start bit, then the given bits lsb first, then back to mark
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i <= n; i++) begin
            @(negedge clk_sys_in);
            line_out <= (i == 0) ? 1'b0 : bits[i-1];
            repeat (BIT_CYCLES - 1) @(negedge clk_sys_in);
        end
        @(negedge clk_sys_in);
        line_out <= 1'b1;
    endtask

    // unsampled positions stay at mark so a lost frame matches only an all-mark frame
    task automatic get(input int n, output logic [11:0] bits);
        int t;
        bits = '1;
        for (t = 0; t < 2000 && line_in !== 1'b0; t++) @(posedge clk_sys_in);
        repeat (BIT_CYCLES / 2) @(posedge clk_sys_in);
        for (int i = 0; i < n; i++) begin
            repeat (BIT_CYCLES) @(posedge clk_sys_in);
            bits[i] = line_in;
        end
    endtask
endmodule

`default_nettype wire

// *** verification/asm_serial_tb.sv ***
/*
 * Self-checking bench for the two-channel serial block.
 * Assumes the checker is bound in and a remote station on each line.
 */
`default_nettype none

module asm_serial_tb;
    import asm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int BITC = 4;
    logic        clk_sys_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        io_wr_in = 1'b0;
    logic        io_rd_in = 1'b0;
    logic        carrier_detect_in = 1'b1;
    logic [7:0]  io_addr_in = 8'h00;
    logic [7:0]  io_wdata_in = 8'h00;
    logic [7:0]  io_rdata_out, d, b, c, dm;
    wire  [1:0]  rxd_in;
    logic [1:0]  txd_out, rx_irq_out, tx_irq_out;
    logic [11:0] g;
    logic        m, xb, bad;
    int          err_count = 0;
    int          cmp_count = 0;
    int          n, s, t;

    always #5 clk_sys_in = ~clk_sys_in;

    asm_serial #(.BIT_CYCLES(BITC)) dut (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .io_addr_in(io_addr_in),
        .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
        .io_rdata_out(io_rdata_out), .rxd_in(rxd_in), .txd_out(txd_out),
        .carrier_detect_in(carrier_detect_in), .rx_irq_out(rx_irq_out),
        .tx_irq_out(tx_irq_out));
    asm_remote #(.BIT_CYCLES(BITC)) rem0 (.clk_sys_in(clk_sys_in),
        .line_in(txd_out[0]), .line_out(rxd_in[0]));
    asm_remote #(.BIT_CYCLES(BITC)) rem1 (.clk_sys_in(clk_sys_in),
        .line_in(txd_out[1]), .line_out(rxd_in[1]));

    task automatic chk(input string what, input logic [11:0] e,
                       input logic [11:0] v);
        cmp_count++;
        if (v !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, v);
        end
    endtask

    // one-cycle strobes, changed on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(negedge clk_sys_in);
        io_addr_in <= a;
        io_wdata_in <= w;
        io_wr_in <= 1'b1;
        @(negedge clk_sys_in);
        io_wr_in <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] k,
                      input logic [7:0] e);
        @(negedge clk_sys_in);
        io_addr_in <= a;
        io_rd_in <= 1'b1;
        @(negedge clk_sys_in);
        io_rd_in <= 1'b0;
        chk("register read", 12'(e & k), 12'(io_rdata_out & k));
    endtask

    // data lsb first, then the flag or parity bit, stops and idle at mark
    function automatic logic [11:0] frame(input logic [7:0] w, input int l,
                                          input logic x);
        logic [11:0] f;
        f = '1;
        for (int i = 0; i < l; i++) f[i] = w[i];
        f[l] = x;
        return f;
    endfunction

    task automatic give_verdict();
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'hDBCD));
        repeat (6) @(negedge clk_sys_in);
        nrst_in <= 1'b1;
        rc(ASM_OFS_SERIAL_STATUS_CH0, 8'hF7, 8'h06);
        rc(ASM_OFS_SERIAL_STATUS_CH1, 8'hFF, 8'h02);
        rc(ASM_OFS_CTL_B0, 8'h7F, 8'h07);
        rc(ASM_OFS_CTL_B1, 8'h7F, 8'h07);
        rc(8'h3F, 8'hFF, 8'h00);
        carrier_detect_in <= 1'b0;
        wr(ASM_OFS_SERIAL_STATUS_CH0, 8'hFF);
        rc(ASM_OFS_SERIAL_STATUS_CH0, 8'hFF, 8'h0B);
        wr(ASM_OFS_SERIAL_STATUS_CH1, 8'hFF);
        rc(ASM_OFS_SERIAL_STATUS_CH1, 8'hFF, 8'h0B);
        // every length, stop count, parity or multiprocessor framing on both channels
        for (int k = 0; k < 16; k++) begin
            c = 8'(k % 2);
            n = 7 + k[1];
            s = 1 + k[2];
            m = k[3];
            d = (k == 0) ? 8'h00 : (k == 15) ? 8'hFF : 8'($urandom);
            b = 8'($urandom);
            wr(ASM_OFS_CTL_A0 + c, {4'h0, 1'b0, k[1], m ? b[1] : 1'b1, k[2]});
            wr(ASM_OFS_CTL_B0 + c, {b[7], m, b[5:0]});
            dm = k[1] ? d : {1'b0, d[6:0]};
            xb = m ? b[7] : (^dm ^ b[4]);
            wr(ASM_OFS_TXD0 + c, d);
            if (c[0]) rem1.get(n + s + 2, g);
            else rem0.get(n + s + 2, g);
            chk("tx frame", frame(dm, n, xb), g);
            chk("tx request", 12'h001, 12'(tx_irq_out[c]));
            d = 8'($urandom);
            bad = 1'($urandom);
            dm = k[1] ? d : {1'b0, d[6:0]};
            xb = m ? bad : (^dm ^ b[4] ^ bad);
            if (c[0]) rem1.send(frame(dm, n, xb), n + 1 + s);
            else rem0.send(frame(dm, n, xb), n + 1 + s);
            for (t = 0; t < 400 && rx_irq_out[c] !== 1'b1; t++)
                @(negedge clk_sys_in);
            rc(ASM_OFS_RXD0 + c, k[1] ? 8'hFF : 8'h7F, dm);
            rc(ASM_OFS_CTL_A0 + c, 8'h80, {m & bad, 7'h00});
            rc(ASM_OFS_SERIAL_STATUS_CH0 + c, 8'hF0, {2'b00, !m & bad, 5'h00});
            chk("rx request", 12'(!m & bad), 12'(rx_irq_out[c]));
        end
        wr(ASM_OFS_SERIAL_STATUS_CH0, 8'h00);
        wr(ASM_OFS_SERIAL_STATUS_CH1, 8'h00);
        repeat (3) @(negedge clk_sys_in);
        chk("requests off", 12'h000, 12'({rx_irq_out, tx_irq_out}));
        give_verdict();
    end
endmodule

`default_nettype wire
